// ### rtl/cycle_timer.sv
// Purpose: Wake pulse generator for duty-cycled accelerometer sampling
// Assumes: divider is stable while enable is high
// Notes:   Wake period is (divider + 1) * BASE_CYC clock cycles
`include "pwr_clk_defs.svh"
`default_nettype none
module cycle_timer #(
    parameter int BASE_CYC = `CYCLE_BASE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Control link
    cycle_timer_if.timer tif
);
    import pwr_clk_pkg::*;

    localparam logic [15:0] PRE_LAST = 16'(BASE_CYC - 1);

    logic [15:0] pre_reg;
    logic [7:0] div_reg;
    logic wake_reg;
    logic base_tick;

    assign base_tick = tif.enable && (pre_reg == PRE_LAST);
    assign tif.wake = wake_reg;

    // Dropping enable restarts the period so the first wake is a full one
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pre_reg <= 16'h0000;
        end else if (!tif.enable || base_tick) begin
            pre_reg <= 16'h0000;
        end else begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= 8'h00;
        end else if (!tif.enable) begin
            div_reg <= 8'h00;
        end else if (base_tick) begin
            if (div_reg >= tif.divider) begin
                div_reg <= 8'h00;
            end else begin
                div_reg <= div_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= base_tick && (div_reg >= tif.divider);
        end
    end

    // A wake needs a whole base period of enable behind it
    a_wake_needs_en: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        tif.wake |-> $past(tif.enable) && $past(tif.enable, BASE_CYC))
        else $error("wake pulse without cycle enable");
endmodule
`default_nettype wire

// ### rtl/cycle_timer_if.sv
// Purpose: Link between the control registers and the wake timer
// Assumes: Both ends run on sys_clk
// Notes:   wake is a one-cycle pulse
`default_nettype none
interface cycle_timer_if;
    logic enable;
    logic [7:0] divider;
    logic wake;
    modport ctrl (output enable, output divider, input wake);
    modport timer (input enable, input divider, output wake);
endinterface
`default_nettype wire

// ### rtl/power_clock_interface_ctrl.sv
// Purpose: Power, clock source, axis standby and serial port control
// Assumes: Register strobes come from the serial front end on sys_clk
// Notes:   pll_ready is analog-side and is synchronised here
//
// Behaviour
// - Reset bit write restores all register defaults
// - Reset bit self-clears when reset completes
// - Sleep bit puts device into sleep
// - Cycle mode alternates sleep and accel sample
// - All accel axes off: wake, no sample
// - Gyro standby keeps drive, PLL; sense off
// - Temperature disable bit turns sensor off
// - Codes 0 and 6 select internal oscillator
// - Codes 1-5 use PLL if ready, else oscillator
// - Code 7 stops clock, holds timing reset
// - Clock select resets to 001
// - Accel standby bits 5..3 disable axes
// - Gyro standby bits 2..0 disable axes
// - Two-wire disable forces SPI-only port
// - Count high reports upper count byte
// - High byte read latches coherent snapshot
`include "pwr_clk_defs.svh"
`default_nettype none
module power_clock_interface_ctrl #(
    parameter int BASE_CYC = `CYCLE_BASE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port from the serial front end
    input wire pwr_clk_pkg::reg_addr_t reg_addr,
    input wire pwr_clk_pkg::reg_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output pwr_clk_pkg::reg_byte_t reg_rdata,
    // Status from the rest of the device
    input wire logic pll_ready,
    input wire logic [15:0] fifo_count,
    input wire logic [7:0] sample_rate_divider,
    // Power controls
    output logic device_sleep,
    output logic cycle_wake,
    output logic accel_sample,
    output logic [2:0] accel_axis_en,
    output logic gyro_drive_en,
    output logic pll_en,
    output logic [2:0] gyro_sense_en,
    output logic temp_sensor_en,
    output logic regs_resetting,
    // Clock controls
    output logic use_pll,
    output logic clock_stop,
    output logic timing_gen_reset,
    // Serial port control
    output logic two_wire_enable
);
    import pwr_clk_pkg::*;

    localparam logic [7:0] SR_LAST = 8'(`SOFT_RESET_CYC - 1);

    function automatic clk_src_t decode_clk_src(input logic [2:0] sel,
                                                input logic ready);
        clk_src_t src;
        src = SRC_OSC;
        case (sel)
            `CLOCK_SOURCE_SELECT_OSC_A, `CLOCK_SOURCE_SELECT_OSC_B: src = SRC_OSC;
            `CLOCK_SOURCE_SELECT_STOP: src = SRC_STOP;
            default: src = ready ? SRC_PLL : SRC_OSC;
        endcase
        return src;
    endfunction

    cycle_timer_if tif ();

    soft_rst_state_t sr_state_reg;
    logic [7:0] sr_cnt_reg;
    logic sr_done;
    reg_byte_t pcp_reg;
    reg_byte_t axs_reg;
    reg_byte_t spc_reg;
    logic [15:0] snap_reg;
    logic pll_meta_reg;
    logic pll_sync_reg;
    logic wr_pcp;
    logic wr_axs;
    logic wr_spc;
    logic rd_high;
    logic rd_low;
    logic sleep_bit;
    logic gstby_bit;
    logic cycle_eff;
    logic [2:0] accel_on;
    logic [2:0] rot_on;
    clk_src_t src_next;
    reg_byte_t rdata_next;

    assign sr_done = (sr_state_reg == SR_BUSY) && (sr_cnt_reg == SR_LAST);
    assign wr_pcp = reg_wr && (reg_addr == `REG_PWR_PRIMARY);
    assign wr_axs = reg_wr && (reg_addr == `REG_AXIS_STBY);
    assign wr_spc = reg_wr && (reg_addr == `REG_SERIAL_CFG);
    assign rd_high = reg_rd && (reg_addr == `REG_QCOUNT_HIGH);
    assign rd_low = reg_rd && (reg_addr == `REG_QCOUNT_LOW);

    // PLL lock comes from the analog side, so it is resynchronised
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pll_meta_reg <= 1'b0;
            pll_sync_reg <= 1'b0;
        end else begin
            pll_meta_reg <= pll_ready;
            pll_sync_reg <= pll_meta_reg;
        end
    end

    // Soft reset sequencer; register writes are ignored while it runs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sr_state_reg <= SR_IDLE;
            sr_cnt_reg <= 8'h00;
        end else begin
            case (sr_state_reg)
                SR_IDLE: begin
                    sr_cnt_reg <= 8'h00;
                    if (wr_pcp && reg_wdata[`PCP_RESET_BIT]) begin
                        sr_state_reg <= SR_BUSY;
                    end
                end
                SR_BUSY: begin
                    if (sr_done) begin
                        sr_state_reg <= SR_IDLE;
                        sr_cnt_reg <= 8'h00;
                    end else begin
                        sr_cnt_reg <= sr_cnt_reg + 8'h01;
                    end
                end
                default: begin
                    sr_state_reg <= SR_IDLE;
                    sr_cnt_reg <= 8'h00;
                end
            endcase
        end
    end

    // A reset write carries no other settings; the defaults win
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pcp_reg <= `PCP_RESET_VAL;
        end else if (sr_done) begin
            pcp_reg <= `PCP_RESET_VAL;
        end else if (wr_pcp && (sr_state_reg == SR_IDLE) &&
                     !reg_wdata[`PCP_RESET_BIT]) begin
            pcp_reg <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            axs_reg <= `AXS_RESET_VAL;
            spc_reg <= `SPC_RESET_VAL;
        end else if (sr_done) begin
            axs_reg <= `AXS_RESET_VAL;
            spc_reg <= `SPC_RESET_VAL;
        end else if (sr_state_reg == SR_IDLE) begin
            if (wr_axs) begin
                axs_reg <= reg_wdata & `AXS_USED_MASK;
            end
            if (wr_spc) begin
                spc_reg <= reg_wdata & `SPC_USED_MASK;
            end
        end
    end

    // Count snapshot: high read returns live byte and freezes the pair
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            snap_reg <= 16'h0000;
        end else if (rd_high) begin
            snap_reg <= fifo_count;
        end else if (rd_low) begin
            snap_reg <= fifo_count;
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        case (reg_addr)
            `REG_PWR_PRIMARY: begin
                rdata_next = pcp_reg;
                rdata_next[`PCP_RESET_BIT] = (sr_state_reg == SR_BUSY);
            end
            `REG_AXIS_STBY: rdata_next = axs_reg;
            `REG_SERIAL_CFG: rdata_next = spc_reg;
            `REG_QCOUNT_HIGH: rdata_next = fifo_count[15:8];
            `REG_QCOUNT_LOW: rdata_next = snap_reg[7:0];
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

    assign sleep_bit = pcp_reg[`PCP_SLEEP_BIT];
    assign gstby_bit = pcp_reg[`PCP_GSTBY_BIT];
    assign cycle_eff = pcp_reg[`PCP_CYCLE_BIT] && !sleep_bit &&
                       !gstby_bit;
    assign accel_on = ~{axs_reg[`AXS_ACCEL_X_BIT], axs_reg[`AXS_ACCEL_Y_BIT],
                        axs_reg[`AXS_ACCEL_Z_BIT]};
    assign rot_on = ~{axs_reg[`AXS_ROT_X_BIT], axs_reg[`AXS_ROT_Y_BIT],
                      axs_reg[`AXS_ROT_Z_BIT]};
    assign src_next = decode_clk_src(
        pcp_reg[`PCP_CLOCK_SOURCE_SELECT_MSB:`PCP_CLOCK_SOURCE_SELECT_LSB], pll_sync_reg);

    assign tif.enable = cycle_eff;
    assign tif.divider = sample_rate_divider;

    cycle_timer #(
        .BASE_CYC(BASE_CYC)
    ) u_cycle_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .tif(tif)
    );

    // Sleep and duty cycling; in cycle mode the part sleeps between wakes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            device_sleep <= 1'b0;
            cycle_wake <= 1'b0;
            accel_sample <= 1'b0;
        end else begin
            device_sleep <= sleep_bit || (cycle_eff && !tif.wake);
            cycle_wake <= cycle_eff && tif.wake;
            accel_sample <= cycle_eff && tif.wake && (|accel_on);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            accel_axis_en <= 3'h0;
            gyro_sense_en <= 3'h0;
            gyro_drive_en <= 1'b0;
            pll_en <= 1'b0;
            temp_sensor_en <= 1'b0;
        end else begin
            accel_axis_en <= sleep_bit ? 3'h0 : accel_on;
            gyro_sense_en <= (sleep_bit || gstby_bit || cycle_eff) ?
                             3'h0 : rot_on;
            gyro_drive_en <= !sleep_bit && !cycle_eff &&
                             (gstby_bit || (|rot_on));
            pll_en <= !sleep_bit && !cycle_eff &&
                      (gstby_bit || (|rot_on));
            temp_sensor_en <= !sleep_bit &&
                              !pcp_reg[`PCP_TDIS_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            use_pll <= 1'b0;
            clock_stop <= 1'b0;
            timing_gen_reset <= 1'b1;
            regs_resetting <= 1'b0;
            two_wire_enable <= 1'b1;
        end else begin
            use_pll <= (src_next == SRC_PLL);
            clock_stop <= (src_next == SRC_STOP);
            timing_gen_reset <= (src_next == SRC_STOP);
            regs_resetting <= (sr_state_reg == SR_BUSY);
            two_wire_enable <= !spc_reg[`SPC_TWI_DIS_BIT];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    localparam int SR_DONE = `SOFT_RESET_CYC + 1;

    sequence s_reset_req;
        wr_pcp && reg_wdata[`PCP_RESET_BIT] && (sr_state_reg == SR_IDLE);
    endsequence

    sequence s_reset_back;
        (sr_state_reg == SR_IDLE) &&
        (pcp_reg[`PCP_CLOCK_SOURCE_SELECT_MSB:`PCP_CLOCK_SOURCE_SELECT_LSB] == `CLOCK_SOURCE_SELECT_DEFAULT) &&
        (axs_reg == `AXS_RESET_VAL);
    endsequence

    a_reset_self_clear: assert property (
        s_reset_req |=> (sr_state_reg == SR_BUSY) ##(SR_DONE - 1)
        s_reset_back) else $error("soft reset did not finish on time");

    a_reset_defaults: assert property (
        s_reset_req |-> ##SR_DONE (pcp_reg == `PCP_RESET_VAL) &&
        (spc_reg == `SPC_RESET_VAL))
        else $error("soft reset left a register off default");

    a_clk_stop_code: assert property (
        (pcp_reg[`PCP_CLOCK_SOURCE_SELECT_MSB:`PCP_CLOCK_SOURCE_SELECT_LSB] == `CLOCK_SOURCE_SELECT_STOP) |=>
        clock_stop && timing_gen_reset && !use_pll)
        else $error("clock select 7 did not stop the clock");

    a_clk_auto_pll: assert property (
        ((pcp_reg[2:0] >= 3'h1) && (pcp_reg[2:0] <= 3'h5)) |=>
        (use_pll == $past(pll_sync_reg)) && !clock_stop)
        else $error("clock source choice wrong");

    a_osc_codes: assert property (
        ((pcp_reg[2:0] == `CLOCK_SOURCE_SELECT_OSC_A) || (pcp_reg[2:0] == `CLOCK_SOURCE_SELECT_OSC_B))
        |=> !use_pll && !clock_stop)
        else $error("oscillator code did not select oscillator");

    a_sleep_output: assert property (
        sleep_bit |=> device_sleep && !accel_sample && !temp_sensor_en)
        else $error("sleep bit did not put the device to sleep");

    a_gyro_standby: assert property (
        (gstby_bit && !sleep_bit) |=> gyro_drive_en && pll_en &&
        (gyro_sense_en == 3'h0)) else $error("gyro standby outputs wrong");

    a_cycle_nosample: assert property (
        (cycle_eff && tif.wake && (accel_on == 3'h0)) |=>
        cycle_wake && !accel_sample)
        else $error("sample taken with all accel axes off");

    a_count_coherent: assert property (
        (rd_high ##1 rd_low) |=> (reg_rdata == $past(fifo_count[7:0], 2)))
        else $error("count low byte not from high-byte snapshot");

    a_twi_disable: assert property (
        spc_reg[`SPC_TWI_DIS_BIT] |=> !two_wire_enable)
        else $error("two-wire port not disabled");
endmodule
`default_nettype wire

// ### rtl/pwr_clk_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Registers are 8 bits wide at 7-bit addresses
// Notes:   Included by the timer and control design files of the power/clock block
`ifndef PWR_CLK_DEFS_SVH
`define PWR_CLK_DEFS_SVH

// Register addresses
`define REG_PWR_PRIMARY 7'h6b
`define REG_AXIS_STBY 7'h6c
`define REG_SERIAL_CFG 7'h70
`define REG_QCOUNT_HIGH 7'h72
`define REG_QCOUNT_LOW 7'h73

// power_control_primary fields
`define PCP_RESET_BIT 7
`define PCP_SLEEP_BIT 6
`define PCP_CYCLE_BIT 5
`define PCP_GSTBY_BIT 4
`define PCP_TDIS_BIT 3
`define PCP_CLOCK_SOURCE_SELECT_MSB 2
`define PCP_CLOCK_SOURCE_SELECT_LSB 0

// axis_standby_control fields
`define AXS_ACCEL_X_BIT 5
`define AXS_ACCEL_Y_BIT 4
`define AXS_ACCEL_Z_BIT 3
`define AXS_ROT_X_BIT 2
`define AXS_ROT_Y_BIT 1
`define AXS_ROT_Z_BIT 0
`define AXS_USED_MASK 8'h3f

// serial_port_config fields
`define SPC_TWI_DIS_BIT 6
`define SPC_USED_MASK 8'h40

// Reset values
`define CLOCK_SOURCE_SELECT_DEFAULT 3'h1
`define PCP_RESET_VAL 8'h01
`define AXS_RESET_VAL 8'h00
`define SPC_RESET_VAL 8'h00

// Clock source select codes
`define CLOCK_SOURCE_SELECT_OSC_A 3'h0
`define CLOCK_SOURCE_SELECT_OSC_B 3'h6
`define CLOCK_SOURCE_SELECT_STOP 3'h7

// Timing
`define CLK_PERIOD_NS 10
`define SOFT_RESET_NS 100
`define SOFT_RESET_CYC \
    ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYCLE_BASE_NS 1000
`define CYCLE_BASE_CYC (`CYCLE_BASE_NS / `CLK_PERIOD_NS)

`endif

// ### rtl/pwr_clk_pkg.sv
// Purpose: Types shared by the power/clock control block
// Assumes: Nothing beyond the defines header
// Notes:   Codes are written out so the state is readable in waves
`default_nettype none
package pwr_clk_pkg;
    typedef enum logic [1:0] {
        SRC_OSC = 2'b00,
        SRC_PLL = 2'b01,
        SRC_STOP = 2'b10
    } clk_src_t;

    typedef enum logic [0:0] {
        SR_IDLE = 1'b0,
        SR_BUSY = 1'b1
    } soft_rst_state_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [6:0] reg_addr_t;
endpackage
`default_nettype wire

// ### tb/host_model.sv
// Purpose: Host side of the register port, one strobe per access
// Assumes: Requests change on the falling edge of sys_clk
// Notes:   Released address and data show the inverse of the last value
`default_nettype none
module host_model (
    // Clock
    input wire logic sys_clk,
    // Register port
    output pwr_clk_pkg::reg_addr_t reg_addr,
    output pwr_clk_pkg::reg_byte_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire pwr_clk_pkg::reg_byte_t reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import pwr_clk_pkg::*;

    initial begin
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Strobe lasts exactly one cycle; a stale address must never look valid
    task automatic access(input reg_addr_t a, input reg_byte_t d,
                          input logic w);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        access(a, d, 1'b1);
    endtask

    // Read data is registered, so it is taken one cycle after the strobe
    task automatic rd(input reg_addr_t a, output reg_byte_t d);
        access(a, 8'h00, 1'b0);
        d = reg_rdata;
    endtask

    // Two reads on consecutive edges; the strobe stays up between them
    task automatic rd_pair(input reg_addr_t a, input reg_addr_t b,
                           output reg_byte_t da, output reg_byte_t db);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        da = reg_rdata;
        reg_addr = b;
        @(negedge sys_clk);
        db = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~b;
    endtask
endmodule
`default_nettype wire

// ### tb/test_power_clock_interface_ctrl.sv
// Purpose: Self-checking bench of the power and clock control registers
// Assumes: BASE_CYC shortened to 4 so a wake period is a few cycles
// Notes:   Expected outputs come from a small model of the bit meanings
`default_nettype none
module test_power_clock_interface_ctrl import pwr_clk_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } row_t;

    logic sys_clk, nrst, pll_ready;
    logic [15:0] fifo_count;
    logic [7:0] sample_rate_divider;
    reg_addr_t reg_addr;
    reg_byte_t reg_wdata, reg_rdata, rv, rv2;
    logic reg_wr, reg_rd, regs_resetting, cycle_wake, accel_sample;
    logic device_sleep, gyro_drive_en, pll_en, temp_sensor_en;
    logic use_pll, clock_stop, timing_gen_reset, two_wire_enable;
    logic [2:0] accel_axis_en, gyro_sense_en;
    logic [13:0] outs, e;
    logic [7:0] pcp, axs, spc;
    int err_count, checked;
    row_t rows[17];

    assign outs = {device_sleep, accel_axis_en, gyro_drive_en, pll_en,
                   gyro_sense_en, temp_sensor_en, use_pll, clock_stop,
                   timing_gen_reset, two_wire_enable};

    power_clock_interface_ctrl #(.BASE_CYC(4)) u_power_clock_interface_ctrl (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pll_ready(pll_ready),
        .fifo_count(fifo_count), .sample_rate_divider(sample_rate_divider),
        .device_sleep(device_sleep), .cycle_wake(cycle_wake),
        .accel_sample(accel_sample), .accel_axis_en(accel_axis_en),
        .gyro_drive_en(gyro_drive_en), .pll_en(pll_en),
        .gyro_sense_en(gyro_sense_en), .temp_sensor_en(temp_sensor_en),
        .regs_resetting(regs_resetting), .use_pll(use_pll),
        .clock_stop(clock_stop), .timing_gen_reset(timing_gen_reset),
        .two_wire_enable(two_wire_enable));

    host_model u_host_model (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    function automatic logic [13:0] model(input logic [7:0] p,
            input logic [7:0] a, input logic [7:0] s, input logic pll);
        logic slp, cyc, gd;
        slp = p[6];
        cyc = p[5] & !p[6] & !p[4];
        gd = !slp & !cyc & (p[4] | (|(~a[2:0])));
        model = {slp | cyc, slp ? 3'h0 : ~a[5:3], gd, gd,
                 (slp | p[4] | cyc) ? 3'h0 : ~a[2:0], !slp & !p[3],
                 (p[2:0] >= 3'h1 && p[2:0] <= 3'h5) & pll,
                 p[2:0] == 3'h7, p[2:0] == 3'h7, !s[6]};
    endfunction

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Waits for a wake, then times the gap to the next one
    task automatic measure(input logic samp);
        int n;
        n = 0;
        while (cycle_wake !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check("wake_sample", accel_sample, samp);
        @(negedge sys_clk);
        check("between_sleep", device_sleep, 1'b1);
        n = 1;
        while (cycle_wake !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check("wake_period", 16'(n), 16'd8);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        final_report();
    end

    initial begin
        err_count = 0;
        checked = 0;
        nrst = 1'b0;
        pll_ready = 1'b0;
        fifo_count = 16'h1234;
        sample_rate_divider = 8'h01;
        rows = '{'{7'h6b, 8'h40}, '{7'h6b, 8'h08}, '{7'h6b, 8'h00},
                 '{7'h6b, 8'h01}, '{7'h6b, 8'h02}, '{7'h6b, 8'h03},
                 '{7'h6b, 8'h04}, '{7'h6b, 8'h05}, '{7'h6b, 8'h06},
                 '{7'h6b, 8'h07}, '{7'h6c, 8'h3f}, '{7'h6b, 8'h11},
                 '{7'h6c, 8'h15}, '{7'h70, 8'hff}, '{7'h70, 8'h00},
                 '{7'h6b, 8'h30}, '{7'h6b, 8'h60}};
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        e = model(8'h01, 8'h00, 8'h00, 1'b0);
        check("reset_outs", outs, e);
        u_host_model.rd(7'h6b, rv);
        check("reset_pcp", rv, 8'h01);
        u_host_model.rd(7'h6c, rv);
        check("reset_axs", rv, 8'h00);
        u_host_model.rd(7'h70, rv);
        check("reset_spc", rv, 8'h00);
        pll_ready = 1'b1;
        pcp = 8'h01;
        axs = 8'h00;
        spc = 8'h00;
        foreach (rows[i]) begin
            u_host_model.wr(rows[i].addr, rows[i].data);
            if (rows[i].addr == 7'h6b) pcp = rows[i].data;
            if (rows[i].addr == 7'h6c) axs = rows[i].data & 8'h3f;
            if (rows[i].addr == 7'h70) spc = rows[i].data & 8'h40;
            repeat (4) @(negedge sys_clk);
            e = model(pcp, axs, spc, 1'b1);
            check("power", outs[13:4], e[13:4]);
            check("axes", outs[12:5], e[12:5]);
            check("clk", outs[3:0], e[3:0]);
            u_host_model.rd(rows[i].addr, rv);
            check("readback", rv, rows[i].addr == 7'h6b ? pcp :
                  rows[i].addr == 7'h6c ? axs : spc);
        end
        // Duty cycling, first with accel axes on, then all in standby
        u_host_model.wr(7'h6b, 8'h21);
        measure(1'b1);
        u_host_model.wr(7'h6c, 8'h38);
        measure(1'b0);
        // Full register reset; a write while busy must be lost
        u_host_model.wr(7'h6c, 8'h3f);
        u_host_model.wr(7'h70, 8'h40);
        u_host_model.wr(7'h6b, 8'h80);
        u_host_model.rd(7'h6b, rv);
        check("reset_busy", rv & 8'h80, 8'h80);
        check("resetting", regs_resetting, 1'b1);
        u_host_model.wr(7'h6c, 8'h2a);
        for (int n = 0; n < 50 && regs_resetting === 1'b1; n++) begin
            @(negedge sys_clk);
        end
        u_host_model.rd(7'h6b, rv);
        check("soft_pcp", rv, 8'h01);
        u_host_model.rd(7'h6c, rv);
        check("soft_axs", rv, 8'h00);
        u_host_model.rd(7'h70, rv);
        check("soft_spc", rv, 8'h00);
        // Host keeps the auto clock select for full gyro use
        u_host_model.wr(7'h6b, 8'h01);
        // Byte count snapshot
        u_host_model.rd(7'h72, rv);
        check("count_high", rv, 8'h12);
        @(negedge sys_clk);
        fifo_count = 16'h5678;
        u_host_model.rd(7'h73, rv);
        check("count_low", rv, 8'h34);
        u_host_model.rd(7'h73, rv);
        check("count_fresh", rv, 8'h78);
        u_host_model.wr(7'h72, 8'hff);
        u_host_model.rd(7'h72, rv);
        check("count_ro", rv, 8'h56);
        u_host_model.wr(7'h7f, 8'h55);
        u_host_model.rd(7'h7f, rv);
        check("unmapped", rv, 8'h00);
        // Back-to-back pair: low byte must come from the high-byte read
        fifo_count = 16'h9abc;
        u_host_model.rd_pair(7'h72, 7'h73, rv, rv2);
        check("pair_high", rv, 8'h9a);
        check("pair_low", rv2, 8'hbc);
        final_report();
    end
endmodule
`default_nettype wire
